// file: logic/tcsr_pkg.sv
// package of constants for the trace capture status register block
// assumes an apb slave with 32-bit data and one aligned word per register
package tcsr_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] tcsr_off_status = 8'h00;
  localparam logic [7:0] tcsr_off_control = 8'h04;
  localparam logic [7:0] tcsr_off_irq_status = 8'h08;
  localparam logic [7:0] tcsr_off_irq_mask = 8'h0c;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int tcsr_bit_mem_lo = 0;
  localparam int tcsr_bit_mem_hi = 1;
  localparam int tcsr_bit_addr_latched = 2;
  localparam int tcsr_bit_triggered = 3;
  localparam int tcsr_bit_completed = 4;
  localparam int tcsr_bit_level = 5;
  localparam int tcsr_bit_full = 6;
  localparam int tcsr_bit_unused = 7;

  // control field position
  localparam int tcsr_bit_start = 0;

  // interrupt status layout
  localparam int tcsr_irq_latched = 0;
  localparam int tcsr_irq_triggered = 1;
  localparam int tcsr_irq_completed = 2;
  localparam int tcsr_irq_full = 3;
  localparam int tcsr_irq_width = 4;

  // ---------------------------------------------------------------
  // memory size codes
  // ---------------------------------------------------------------
  localparam logic [1:0] tcsr_mem_256k = 2'h0;
  localparam logic [1:0] tcsr_mem_512k = 2'h1;
  localparam logic [1:0] tcsr_mem_768k = 2'h2;
  localparam logic [1:0] tcsr_mem_1m = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] tcsr_rst_word = 32'h0000_0000;
  localparam logic [3:0] tcsr_rst_irq = 4'h0;

endpackage : tcsr_pkg

// file: logic/tcsr_sticky.sv
// one sticky flag: set by an event, cleared by a condition
// assumes set and clear are single-clock synchronous pulses or levels
`timescale 1ns/1ps
module tcsr_sticky (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);

  // ---------------------------------------------------------------
  // flag
  // ---------------------------------------------------------------
  // set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

endmodule : tcsr_sticky

// file: logic/tcsr_apb_slave.sv
// apb slave front end: decode, strobes and read mux
// assumes an apb master per the protocol; zero wait states
`timescale 1ns/1ps
module tcsr_apb_slave (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] rd_status_in,
  input wire logic [31:0] rd_control_in,
  input wire logic [31:0] rd_irq_status_in,
  input wire logic [31:0] rd_irq_mask_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic wr_control_out,
  output logic wr_irq_status_out,
  output logic wr_irq_mask_out,
  output logic access_out
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic access = psel_in & penable_in;
  wire logic hit_status = paddr_in == tcsr_pkg::tcsr_off_status;
  wire logic hit_control = paddr_in == tcsr_pkg::tcsr_off_control;
  wire logic hit_irq_status = paddr_in == tcsr_pkg::tcsr_off_irq_status;
  wire logic hit_irq_mask = paddr_in == tcsr_pkg::tcsr_off_irq_mask;
  wire logic hit_any = hit_status | hit_control | hit_irq_status
                       | hit_irq_mask;
  wire logic [31:0] next_rdata =
    hit_status ? rd_status_in :
    hit_control ? rd_control_in :
    hit_irq_status ? rd_irq_status_in :
    hit_irq_mask ? rd_irq_mask_in : tcsr_pkg::tcsr_rst_word;

  assign pready_out = 1'b1;
  // unmapped addresses answer with an error and read zero
  assign pslverr_out = access & ~hit_any;
  assign access_out = access;
  assign wr_control_out = access & pwrite_in & hit_control;
  assign wr_irq_status_out = access & pwrite_in & hit_irq_status;
  assign wr_irq_mask_out = access & pwrite_in & hit_irq_mask;

  // ---------------------------------------------------------------
  // read data register, loaded in the setup cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out <= tcsr_pkg::tcsr_rst_word;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      prdata_out <= next_rdata;
    end
  end

endmodule : tcsr_apb_slave

// file: logic/tcsr_top.sv
// trace capture status register with apb access and event interrupt
// assumes capture logic gives one-cycle event pulses synchronous to clk_in
`timescale 1ns/1ps

// Summary of operation
// - two low bits report memory size code
// - bit 2 sets on trigger event
// - bit 2 clears on converter data read
// - bit 3 sets on trigger, clears start
// - bit 4 sets on completion, clears start
// - bit 6 sets on full, clears start
// - bit 5 shows live comparator level
module tcsr_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [1:0] mem_size_in,
  input wire logic trigger_event_in,
  input wire logic trace_done_in,
  input wire logic buffer_full_in,
  input wire logic comparator_in,
  input wire logic adc_data_read_in,
  output logic start_trace_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic wr_control;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic [7:0] status;
  logic [tcsr_pkg::tcsr_irq_width-1:0] irq_status;
  logic [tcsr_pkg::tcsr_irq_width-1:0] irq_mask;
  logic start_trace;
  logic start_prev;
  logic [1:0] mem_size;

  wire logic [31:0] rd_status = {24'h00_0000, status};
  wire logic [31:0] rd_control = {31'h0000_0000, start_trace};
  wire logic [31:0] rd_irq_status = {28'h000_0000, irq_status};
  wire logic [31:0] rd_irq_mask = {28'h000_0000, irq_mask};

  tcsr_apb_slave u_apb (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .rd_status_in(rd_status),
    .rd_control_in(rd_control),
    .rd_irq_status_in(rd_irq_status),
    .rd_irq_mask_in(rd_irq_mask),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .wr_control_out(wr_control),
    .wr_irq_status_out(wr_irq_status),
    .wr_irq_mask_out(wr_irq_mask),
    .access_out()
  );

  // ---------------------------------------------------------------
  // control register and start edge
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_trace <= 1'b0;
    end else if (wr_control) begin
      start_trace <= pwdata_in[tcsr_pkg::tcsr_bit_start];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= start_trace;
    end
  end

  // bits 3, 4 and 6 clear only on the falling edge of start, not while it is low,
  // so an event seen with start low still stays visible
  wire logic start_fall = start_prev & ~start_trace;
  assign start_trace_out = start_trace;

  // memory size is a strap, caught by a clocked register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_size <= tcsr_pkg::tcsr_mem_256k;
    end else begin
      mem_size <= mem_size_in;
    end
  end

  // ---------------------------------------------------------------
  // sticky status flags
  // ---------------------------------------------------------------
  logic addr_latched;
  logic triggered;
  logic completed;
  logic full;
  logic level;

  tcsr_sticky u_latched (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(trigger_event_in),
    .clear_in(adc_data_read_in),
    .flag_out(addr_latched)
  );

  tcsr_sticky u_triggered (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(trigger_event_in),
    .clear_in(start_fall),
    .flag_out(triggered)
  );

  tcsr_sticky u_completed (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(trace_done_in),
    .clear_in(start_fall),
    .flag_out(completed)
  );

  tcsr_sticky u_full (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .set_in(buffer_full_in),
    .clear_in(start_fall),
    .flag_out(full)
  );

  // comparator is registered so the read word comes from flip-flops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level <= 1'b0;
    end else begin
      level <= comparator_in;
    end
  end

  // status has no write strobe at all, so bus writes cannot reach it
  assign status = {1'b0, full, level, completed, triggered, addr_latched,
                   mem_size};

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  wire logic [tcsr_pkg::tcsr_irq_width-1:0] irq_events =
    {buffer_full_in, trace_done_in, trigger_event_in, trigger_event_in};
  wire logic [tcsr_pkg::tcsr_irq_width-1:0] irq_clear =
    wr_irq_status ? pwdata_in[tcsr_pkg::tcsr_irq_width-1:0]
                  : tcsr_pkg::tcsr_rst_irq;
  wire logic [tcsr_pkg::tcsr_irq_width-1:0] next_irq_status =
    irq_events | (irq_status & ~irq_clear);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status <= tcsr_pkg::tcsr_rst_irq;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_mask <= tcsr_pkg::tcsr_rst_irq;
    end else if (wr_irq_mask) begin
      irq_mask <= pwdata_in[tcsr_pkg::tcsr_irq_width-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_irq_status & irq_mask);
    end
  end

endmodule : tcsr_top

// file: verification/tcsr_asserts.sv
// checker for the capture status register block
// assumes zero-wait apb reads, status word loaded in the setup cycle
`timescale 1ns/1ps
module tcsr_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic [1:0] mem_size_in,
  input wire logic trigger_event_in,
  input wire logic trace_done_in,
  input wire logic buffer_full_in,
  input wire logic comparator_in,
  input wire logic adc_data_read_in,
  input wire logic start_trace_out
);
  logic [2:0] adc_hist;
  wire logic at0 = paddr_in == tcsr_pkg::tcsr_off_status;
  wire logic rs = psel_in && !penable_in && !pwrite_in && at0;
  wire logic rd0 = psel_in && penable_in && !pwrite_in && at0;
  wire logic wr0 = psel_in && penable_in && pwrite_in && at0;
  wire logic quiet = !trigger_event_in && !trace_done_in && !buffer_full_in;
  // converter reads in the three cycles before a status setup cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      adc_hist <= 3'h0;
    end else begin
      adc_hist <= {adc_hist[1:0], adc_data_read_in};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // inputs are registered once, then loaded at setup: two cycles old
  a_mem_code: assert property (
    rd0 |-> prdata_out[1:0] == $past(mem_size_in, 2))
    else $error("size code wrong");
  a_level_live: assert property (
    rd0 |-> prdata_out[5] == $past(comparator_in, 2))
    else $error("level wrong");
  a_top_zero: assert property (
    rd0 |-> prdata_out[31:7] == 25'h0)
    else $error("unused bits set");
  a_ro_status: assert property (
    wr0 |=> $stable(start_trace_out))
    else $error("status write had effect");
  a_trig_flag: assert property (
    trigger_event_in && start_trace_out
    ##[1:3] (rs && start_trace_out && adc_hist == 3'h0) ##1 penable_in
    |-> prdata_out[3:2] == 2'h3)
    else $error("trigger flags not set");
  a_done_flag: assert property (
    trace_done_in && start_trace_out
    ##[1:3] (rs && start_trace_out) ##1 penable_in |-> prdata_out[4])
    else $error("done flag not set");
  a_full_flag: assert property (
    buffer_full_in && start_trace_out
    ##[1:3] (rs && start_trace_out) ##1 penable_in |-> prdata_out[6])
    else $error("full flag not set");
  // late events from the capture side may set flags again after the clear
  a_flags_clear: assert property (
    $fell(start_trace_out) && quiet ##1 quiet ##1 rs ##1 penable_in
    |-> {prdata_out[6], prdata_out[4:3]} == 3'h0)
    else $error("flags not cleared");
  a_addr_clear: assert property (
    adc_data_read_in && !trigger_event_in
    ##1 (rs && !trigger_event_in) ##1 penable_in |-> !prdata_out[2])
    else $error("latched flag not cleared");
endmodule : tcsr_asserts

// file: verification/tcsr_capture_model.sv
// capture front end: trigger, then done, then buffer full
// assumes fire_in is a one-cycle command; events only while started
`timescale 1ns/1ps
module tcsr_capture_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic fire_in,
  output logic trig_out,
  output logic done_out,
  output logic full_out
);
  logic [2:0] pipe;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pipe <= 3'h0;
    end else begin
      pipe <= {pipe[1:0], fire_in && start_in};
    end
  end
  assign trig_out = pipe[0];
  assign done_out = pipe[1];
  assign full_out = pipe[2];
endmodule : tcsr_capture_model

// file: verification/tcsr_tb_top.sv
// self-checking bench for the capture status register block
// assumes zero-wait apb slave; capture events come from the model
`timescale 1ns/1ps
module tcsr_tb_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [1:0] mem_size_in = 2'h0;
  logic comparator_in = 1'b0;
  logic adc_data_read_in = 1'b0;
  logic fire = 1'b0;
  logic trigger_event_in, trace_done_in, buffer_full_in, er;
  logic pready_out, pslverr_out, start_trace_out, irq_out;
  logic [31:0] prdata_out, rd;
  int err_count = 0;
  int n_checks = 0;
  int seed = 32'h3b2f;
  int flags = 0;
  tcsr_top DUT (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .mem_size_in(mem_size_in),
    .trigger_event_in(trigger_event_in),
    .trace_done_in(trace_done_in),
    .buffer_full_in(buffer_full_in),
    .comparator_in(comparator_in),
    .adc_data_read_in(adc_data_read_in),
    .start_trace_out(start_trace_out),
    .irq_out(irq_out)
  );
  tcsr_capture_model u_cap (.clk_in(clk_in), .rst_in(rst_in),
    .start_in(start_trace_out),
    .fire_in(fire), .trig_out(trigger_event_in),
    .done_out(trace_done_in), .full_out(buffer_full_in));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the whole request until pready is seen, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask : apb
  task automatic st_chk();
    apb(1'b0, tcsr_pkg::tcsr_off_status, 32'h0);
    chk(rd, 32'(mem_size_in) | 32'(flags) | (32'(comparator_in) << 5));
  endtask : st_chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int m = 0; m < 4; m++) begin
      mem_size_in <= 2'(m);
      comparator_in <= 1'($random(seed));
      repeat (3) @(posedge clk_in);
      st_chk();
    end
    apb(1'b1, tcsr_pkg::tcsr_off_status, $random(seed));
    st_chk();
    $display("size, level and read-only test done");
    apb(1'b1, tcsr_pkg::tcsr_off_irq_mask, 32'h0000_000f);
    apb(1'b1, tcsr_pkg::tcsr_off_control, 32'h1);
    chk(32'(start_trace_out), 32'h1);
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
    // back-to-back reads so each event lands one to three cycles before the second read's setup cycle
    repeat (2) apb(1'b0, tcsr_pkg::tcsr_off_status, 32'h0);
    flags = 32'h5c;
    st_chk();
    apb(1'b0, tcsr_pkg::tcsr_off_irq_status, 32'h0);
    chk(rd, 32'h0000_000f);
    chk(32'(irq_out), 32'h1);
    apb(1'b0, tcsr_pkg::tcsr_off_control, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, tcsr_pkg::tcsr_off_irq_mask, 32'h0);
    @(posedge clk_in);
    chk(32'(irq_out), 32'h0);
    apb(1'b1, tcsr_pkg::tcsr_off_irq_status, 32'h0000_000f);
    apb(1'b1, tcsr_pkg::tcsr_off_irq_mask, 32'h0000_000f);
    @(posedge clk_in);
    chk(32'(irq_out), 32'h0);
    adc_data_read_in <= 1'b1;
    @(posedge clk_in);
    adc_data_read_in <= 1'b0;
    flags = 32'h58;
    st_chk();
    apb(1'b1, tcsr_pkg::tcsr_off_control, 32'h0);
    chk(32'(start_trace_out), 32'h0);
    @(posedge clk_in);
    flags = 0;
    st_chk();
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    $display("capture, interrupt and unmapped test done");
    complete_run();
  end
endmodule : tcsr_tb_top
bind tcsr_top tcsr_asserts u_chk (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .prdata_out(prdata_out),
  .mem_size_in(mem_size_in),
  .trigger_event_in(trigger_event_in),
  .trace_done_in(trace_done_in),
  .buffer_full_in(buffer_full_in),
  .comparator_in(comparator_in),
  .adc_data_read_in(adc_data_read_in),
  .start_trace_out(start_trace_out)
);
